// ### inc/lli_pkg.sv
// Notes on behaviour
// - device supplies the interface clock; all signals launch and sample on rising edge
// - legacy interface protocol is active only while bus mode select is low
// - lanes used: two lowest for S100, four for S200, all eight for S400
// - when device drives data, unused lanes are held low at S100 and S200
// - when link drives data, device ignores lanes unused at current speed
// - device normally drives control and data; link drives only after grant
// - device control codes: 00 idle, 01 status, 10 receive, 11 grant
// - every request stream starts with a 1 and ends with a 0
// - request bits sent first-to-last from bit 0; bits 1 to 3 give type
// - stream lengths: bus 7 or 8, read 9, write 17, acceleration 6
// - immediate request takes the bus on idle without arbitration
// - isochronous request arbitrates on idle without waiting for subaction gap
// - priority and fair requests arbitrate after subaction gap; only fair obeys fairness
// - read returns register by status, write stores it, acceleration enables or disables, 111 reserved
// - bus request bits 4 to 6 give speed; stop bit optional when bit 6 is 0
// - speed codes: 000 S100, 010 S200, 100 S400, others invalid
// - link power status low resets the interface and stops its clock
// - link-on output sends wake-up and flags interrupt when power off or link bit 0
// - status transfer starts autonomously or to answer a register read
// - receive starts per incoming packet; transmit starts by grant after winning
// - register requests: bits 4 to 7 address, write data in 8 to 15, stop 16
// - acceleration request bit 4 enables when 1, disables when 0; bit 5 stop
// - invalid speed request arbitrates normally; link data ignored, null packet sent
// - further bus requests ignored while one is pending; bus reset clears pending
package lli_pkg;
  localparam int IFACE_CLK_KHZ = 49152;
  localparam logic [1:0] CTL_IDLE = 2'h0;
  localparam logic [1:0] CTL_STATUS = 2'h1;
  localparam logic [1:0] CTL_RECEIVE = 2'h2;
  localparam logic [1:0] CTL_GRANT = 2'h3;
  localparam logic [1:0] CTL_HOLD = 2'h1;
  localparam logic [1:0] CTL_TRANSMIT = 2'h2;
  localparam logic [2:0] RQ_IMM = 3'h0;
  localparam logic [2:0] RQ_ISO = 3'h1;
  localparam logic [2:0] RQ_PRI = 3'h2;
  localparam logic [2:0] RQ_FAIR = 3'h3;
  localparam logic [2:0] RQ_RD = 3'h4;
  localparam logic [2:0] RQ_WR = 3'h5;
  localparam logic [2:0] RQ_ACCEL = 3'h6;
  localparam logic [2:0] RQ_RSV = 3'h7;
  localparam logic [2:0] SPD_S100 = 3'h0;
  localparam logic [2:0] SPD_S200 = 3'h2;
  localparam logic [2:0] SPD_S400 = 3'h4;
  localparam logic [7:0] MASK_S100 = 8'h03;
  localparam logic [7:0] MASK_S200 = 8'h0F;
  localparam logic [7:0] MASK_S400 = 8'hFF;
  localparam logic [4:0] LEN_BUS_SHORT = 5'h07;
  localparam logic [4:0] LEN_BUS_LONG = 5'h08;
  localparam logic [4:0] LEN_RD = 5'h09;
  localparam logic [4:0] LEN_WR = 5'h11;
  localparam logic [4:0] LEN_ACCEL = 5'h06;
  localparam logic [4:0] LEN_TYPE_KNOWN = 5'h04;
  localparam int POS_START = 0;
  localparam int POS_TYPE = 1;
  localparam int POS_SPEED = 4;
  localparam int POS_SPEED_LAST = 6;
  localparam int POS_ADDR = 4;
  localparam int POS_DATA = 8;
  localparam int POS_ACCEL = 4;
  localparam int W_FIELD3 = 3;
  localparam int W_ADDR = 4;
  localparam int W_DATA = 8;
  localparam logic START_BIT = 1'b1;
  localparam logic STOP_BIT = 1'b0;
  localparam logic [3:0] STAT_BEATS = 4'h8;
  localparam logic [3:0] STAT_PAD = 4'h0;
  typedef struct packed {
    logic valid;
    logic [2:0] kind;
    logic [2:0] speed;
  } lli_busreq_t;
  typedef struct packed {
    logic valid;
    logic null_pkt;
    logic [7:0] data;
  } lli_tx_t;
endpackage

// ### verilog/lli_phy_link_if.sv
`timescale 1ns/1ps
module lli_phy_link_if (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic bus_mode_select,
  input wire logic link_power_status,
  input wire logic link_active_bit,
  input wire logic wake_pulse,
  input wire logic irq_pending,
  input wire logic link_request_line,
  input wire logic [1:0] ctl_i,
  output logic [1:0] ctl_o,
  output logic ctl_oe,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe,
  output logic link_on_wake_output,
  output logic iface_clk_run,
  input wire logic bus_reset,
  input wire logic bus_idle_detected,
  input wire logic subaction_gap_detected,
  input wire logic arb_won,
  input wire logic arb_lost,
  input wire logic rx_active,
  input wire logic [7:0] rx_data,
  input wire logic [2:0] rx_speed,
  input wire logic stat_auto_req,
  input wire logic [15:0] stat_auto_word,
  input wire logic [7:0] reg_rd_data,
  output lli_pkg::lli_busreq_t pend_req,
  output logic take_bus_now,
  output logic arbitrate_now,
  output logic fair_protocol,
  output logic reg_wr_valid,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_pending,
  output logic accel_enable,
  output logic stat_done,
  output lli_pkg::lli_tx_t tx_out,
  output logic tx_done
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_STATUS = 5'b00010,
    S_RECV = 5'b00100,
    S_GRANT = 5'b01000,
    S_LINK = 5'b10000
  } lli_state_t;

  function automatic logic [7:0] lane_mask(input logic [2:0] spd);
    case (spd)
      lli_pkg::SPD_S100: lane_mask = lli_pkg::MASK_S100;
      lli_pkg::SPD_S200: lane_mask = lli_pkg::MASK_S200;
      lli_pkg::SPD_S400: lane_mask = lli_pkg::MASK_S400;
      default: lane_mask = lli_pkg::MASK_S100;
    endcase
  endfunction

  function automatic logic speed_ok(input logic [2:0] spd);
    speed_ok = (spd == lli_pkg::SPD_S100) || (spd == lli_pkg::SPD_S200)
      || (spd == lli_pkg::SPD_S400);
  endfunction

  function automatic logic [7:0] msb_field(input logic [16:0] b, input int pos, input int w);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < w; i++) begin
      r = {r[6:0], b[pos + i]};
    end
    msb_field = r;
  endfunction

  function automatic logic [4:0] req_len(input logic [16:0] b);
    logic [2:0] t;
    t = 3'(msb_field(b, lli_pkg::POS_TYPE, lli_pkg::W_FIELD3));
    case (t)
      lli_pkg::RQ_RD: req_len = lli_pkg::LEN_RD;
      lli_pkg::RQ_WR: req_len = lli_pkg::LEN_WR;
      lli_pkg::RQ_ACCEL: req_len = lli_pkg::LEN_ACCEL;
      default: req_len = b[lli_pkg::POS_SPEED_LAST] ? lli_pkg::LEN_BUS_LONG
        : lli_pkg::LEN_BUS_SHORT;
    endcase
  endfunction

  lli_state_t state_ff;
  logic if_off;
  logic col_ff;
  logic [4:0] cnt_ff;
  logic [16:0] bits_ff;
  logic [16:0] bits_cur;
  logic done_ff;
  logic [2:0] dec_kind;
  logic [2:0] dec_speed;
  logic [3:0] dec_addr;
  logic [7:0] dec_data;
  lli_pkg::lli_busreq_t pend_ff;
  logic rd_pend_ff;
  logic [3:0] rd_addr_ff;
  logic [15:0] stat_sr_ff;
  logic [3:0] beat_ff;
  logic stat_rd_ff;
  logic stat_done_ff;
  logic [7:0] out_mask_ff;
  logic [2:0] tx_spd_ff;
  logic grant_now;
  logic recv_now;
  logic rd_go;

  // power status low or non-legacy mode holds the interface in reset
  assign if_off = !rst_n || !link_power_status || bus_mode_select;

  always_comb begin
    bits_cur = bits_ff;
    bits_cur[cnt_ff] = link_request_line;
  end

  assign dec_kind = 3'(msb_field(bits_ff, lli_pkg::POS_TYPE, lli_pkg::W_FIELD3));
  assign dec_speed = 3'(msb_field(bits_ff, lli_pkg::POS_SPEED, lli_pkg::W_FIELD3));
  assign dec_addr = 4'(msb_field(bits_ff, lli_pkg::POS_ADDR, lli_pkg::W_ADDR));
  assign dec_data = msb_field(bits_ff, lli_pkg::POS_DATA, lli_pkg::W_DATA);

  // serial request deserialiser; a bad stop bit drops the whole stream
  always_ff @(posedge ref_clk) begin
    if (if_off) begin
      col_ff <= 1'b0;
      cnt_ff <= 5'h00;
      bits_ff <= 17'h00000;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (!col_ff) begin
        if (link_request_line == lli_pkg::START_BIT) begin
          col_ff <= 1'b1;
          bits_ff <= 17'h00000;
          bits_ff[lli_pkg::POS_START] <= lli_pkg::START_BIT;
          cnt_ff <= 5'h01;
        end
      end else begin
        bits_ff <= bits_cur;
        cnt_ff <= cnt_ff + 5'h01;
        if (cnt_ff >= lli_pkg::LEN_TYPE_KNOWN && dec_kind == lli_pkg::RQ_RSV) begin
          col_ff <= 1'b0;
        end else if (cnt_ff >= lli_pkg::LEN_TYPE_KNOWN
            && cnt_ff == req_len(bits_cur) - 5'h01) begin
          col_ff <= 1'b0;
          done_ff <= (req_len(bits_cur) == lli_pkg::LEN_BUS_SHORT)
            || (link_request_line == lli_pkg::STOP_BIT);
        end
      end
    end
  end

  assign grant_now = (state_ff == S_IDLE) && !rx_active && arb_won && pend_ff.valid;
  assign recv_now = (state_ff == S_IDLE || state_ff == S_STATUS) && rx_active;
  // an answered read still looks pending for one cycle; do not send it twice
  assign rd_go = rd_pend_ff && !stat_done_ff;

  // pending bus request; one at a time, dropped on bus reset
  always_ff @(posedge ref_clk) begin
    if (if_off || bus_reset) begin
      pend_ff <= '0;
    end else if (grant_now) begin
      pend_ff.valid <= 1'b0;
    end else if (arb_lost && pend_ff.kind != lli_pkg::RQ_ISO) begin
      pend_ff.valid <= 1'b0;
    end else if (recv_now && (pend_ff.kind == lli_pkg::RQ_PRI
        || pend_ff.kind == lli_pkg::RQ_FAIR)) begin
      pend_ff.valid <= 1'b0;
    end else if (done_ff && !dec_kind[2] && !pend_ff.valid) begin
      pend_ff <= '{valid: 1'b1, kind: dec_kind, speed: dec_speed};
    end
  end

  assign pend_req = pend_ff;
  assign take_bus_now = pend_ff.valid && pend_ff.kind == lli_pkg::RQ_IMM
    && bus_idle_detected;
  assign arbitrate_now = pend_ff.valid && ((pend_ff.kind == lli_pkg::RQ_ISO && bus_idle_detected)
    || ((pend_ff.kind == lli_pkg::RQ_PRI || pend_ff.kind == lli_pkg::RQ_FAIR)
    && subaction_gap_detected));
  assign fair_protocol = pend_ff.valid && pend_ff.kind == lli_pkg::RQ_FAIR;

  // register write strobe and read bookkeeping; bus reset keeps a read pending
  always_ff @(posedge ref_clk) begin
    if (if_off) begin
      reg_wr_valid <= 1'b0;
      reg_addr <= 4'h0;
      reg_wr_data <= 8'h00;
    end else begin
      reg_wr_valid <= done_ff && dec_kind == lli_pkg::RQ_WR;
      if (done_ff && dec_kind == lli_pkg::RQ_WR) begin
        reg_addr <= dec_addr;
        reg_wr_data <= dec_data;
      end else if (done_ff && dec_kind == lli_pkg::RQ_RD && !rd_pend_ff) begin
        // address out early so the read data is settled when status starts
        reg_addr <= dec_addr;
      end else if (rd_pend_ff) begin
        reg_addr <= rd_addr_ff;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (if_off) begin
      rd_pend_ff <= 1'b0;
      rd_addr_ff <= 4'h0;
    end else if (done_ff && dec_kind == lli_pkg::RQ_RD && !rd_pend_ff) begin
      rd_pend_ff <= 1'b1;
      rd_addr_ff <= dec_addr;
    end else if (stat_done_ff && stat_rd_ff) begin
      rd_pend_ff <= 1'b0;
    end
  end

  assign reg_rd_pending = rd_pend_ff;
  assign stat_done = stat_done_ff;

  // acceleration comes back on after reset and with every isochronous request
  always_ff @(posedge ref_clk) begin
    if (if_off || bus_reset) begin
      accel_enable <= 1'b1;
    end else if (done_ff && dec_kind == lli_pkg::RQ_ACCEL) begin
      accel_enable <= bits_ff[lli_pkg::POS_ACCEL];
    end else if (done_ff && dec_kind == lli_pkg::RQ_ISO) begin
      accel_enable <= 1'b1;
    end
  end

  // interface ownership and control bus encoding
  always_ff @(posedge ref_clk) begin
    if (if_off) begin
      state_ff <= S_IDLE;
      ctl_o <= lli_pkg::CTL_IDLE;
      ctl_oe <= 1'b0;
      data_o <= 8'h00;
      data_oe <= 1'b0;
      out_mask_ff <= lli_pkg::MASK_S100;
      stat_sr_ff <= 16'h0000;
      beat_ff <= 4'h0;
      stat_rd_ff <= 1'b0;
      stat_done_ff <= 1'b0;
      tx_spd_ff <= lli_pkg::SPD_S100;
    end else begin
      stat_done_ff <= 1'b0;
      case (state_ff)
        S_IDLE, S_STATUS: begin
          ctl_oe <= 1'b1;
          data_oe <= 1'b1;
          if (recv_now) begin
            // a read-answer status cut short by a packet is resent from the start later; an autonomous one only if stat_auto_req comes again
            state_ff <= S_RECV;
            ctl_o <= lli_pkg::CTL_RECEIVE;
            data_o <= rx_data & lane_mask(rx_speed);
            out_mask_ff <= lane_mask(rx_speed);
          end else if (grant_now) begin
            state_ff <= S_GRANT;
            ctl_o <= lli_pkg::CTL_GRANT;
            data_o <= 8'h00;
            tx_spd_ff <= pend_ff.speed;
          end else if (state_ff == S_IDLE && (rd_go || stat_auto_req)) begin
            state_ff <= S_STATUS;
            ctl_o <= lli_pkg::CTL_STATUS;
            stat_rd_ff <= rd_go;
            stat_sr_ff <= {stat_auto_word[13:0], 2'h0};
            data_o <= {6'h00, stat_auto_word[15:14]};
            if (rd_go) begin
              stat_sr_ff <= {rd_addr_ff[1:0], reg_rd_data, lli_pkg::STAT_PAD, 2'h0};
              data_o <= {6'h00, rd_addr_ff[3:2]};
            end
            out_mask_ff <= lli_pkg::MASK_S100;
            beat_ff <= 4'h1;
          end else if (state_ff == S_STATUS && beat_ff != lli_pkg::STAT_BEATS) begin
            data_o <= {6'h00, stat_sr_ff[15:14]};
            stat_sr_ff <= stat_sr_ff << 2;
            beat_ff <= beat_ff + 4'h1;
          end else begin
            stat_done_ff <= state_ff == S_STATUS;
            state_ff <= S_IDLE;
            ctl_o <= lli_pkg::CTL_IDLE;
            data_o <= 8'h00;
          end
        end
        S_RECV: begin
          if (rx_active) begin
            data_o <= rx_data & lane_mask(rx_speed);
            out_mask_ff <= lane_mask(rx_speed);
          end else begin
            state_ff <= S_IDLE;
            ctl_o <= lli_pkg::CTL_IDLE;
            data_o <= 8'h00;
          end
        end
        S_GRANT: begin
          state_ff <= S_LINK;
          ctl_oe <= 1'b0;
          data_oe <= 1'b0;
        end
        S_LINK: begin
          if (ctl_i == lli_pkg::CTL_IDLE) begin
            state_ff <= S_IDLE;
            ctl_o <= lli_pkg::CTL_IDLE;
            ctl_oe <= 1'b1;
            data_o <= 8'h00;
            data_oe <= 1'b1;
          end
        end
        default: begin
          state_ff <= S_IDLE;
          ctl_o <= lli_pkg::CTL_IDLE;
        end
      endcase
    end
  end

  // link-driven transmit data; lanes above the speed are dropped
  always_ff @(posedge ref_clk) begin
    if (if_off) begin
      tx_out <= '0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= state_ff == S_LINK && ctl_i == lli_pkg::CTL_IDLE;
      tx_out.valid <= state_ff == S_LINK && ctl_i == lli_pkg::CTL_TRANSMIT;
      tx_out.null_pkt <= !speed_ok(tx_spd_ff);
      tx_out.data <= speed_ok(tx_spd_ff) ? (data_i & lane_mask(tx_spd_ff)) : 8'h00;
    end
  end

  // wake and interrupt share one pin; registered to keep it glitch free
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      link_on_wake_output <= 1'b0;
      iface_clk_run <= 1'b0;
    end else begin
      link_on_wake_output <= wake_pulse
        || (irq_pending && (!link_power_status || !link_active_bit));
      iface_clk_run <= link_power_status && !bus_mode_select;
    end
  end

  sequence s_grant_cycle;
    state_ff == S_GRANT && ctl_o == lli_pkg::CTL_GRANT;
  endsequence
  sequence s_link_owned;
    state_ff == S_LINK && !ctl_oe && !data_oe;
  endsequence

  property p_grant_hands_over;
    @(posedge ref_clk) disable iff (if_off) s_grant_cycle |=> s_link_owned;
  endproperty
  a_grant_hands_over: assert property (p_grant_hands_over)
    else $error("grant not followed by link ownership");

  property p_grant_code;
    @(posedge ref_clk) disable iff (if_off) state_ff == S_GRANT |-> ctl_o == lli_pkg::CTL_GRANT;
  endproperty
  a_grant_code: assert property (p_grant_code)
    else $error("grant state without grant code");

  property p_unused_lanes_low;
    @(posedge ref_clk) disable iff (if_off) data_oe |-> (data_o & ~out_mask_ff) == 8'h00;
  endproperty
  a_unused_lanes_low: assert property (p_unused_lanes_low)
    else $error("unused data lane driven high");

  property p_pend_held;
    @(posedge ref_clk) disable iff (if_off)
      pend_ff.valid && !bus_reset && !arb_won && !arb_lost && !rx_active |=> $stable(pend_ff);
  endproperty
  a_pend_held: assert property (p_pend_held)
    else $error("pending bus request replaced");

  property p_wr_strobe;
    @(posedge ref_clk) disable iff (if_off)
      done_ff && dec_kind == lli_pkg::RQ_WR |=> reg_wr_valid && reg_wr_data == $past(dec_data);
  endproperty
  a_wr_strobe: assert property (p_wr_strobe)
    else $error("register write not issued");

  property p_accel_bit;
    @(posedge ref_clk) disable iff (if_off || bus_reset)
      done_ff && dec_kind == lli_pkg::RQ_ACCEL |=> accel_enable == $past(bits_ff[lli_pkg::POS_ACCEL]);
  endproperty
  a_accel_bit: assert property (p_accel_bit)
    else $error("acceleration control not applied");

  property p_no_reserved;
    @(posedge ref_clk) disable iff (if_off) done_ff |-> dec_kind != lli_pkg::RQ_RSV;
  endproperty
  a_no_reserved: assert property (p_no_reserved)
    else $error("reserved request decoded");

  property p_mode_off;
    @(posedge ref_clk) disable iff (!rst_n) bus_mode_select |=> !ctl_oe && !data_oe;
  endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("driving bus outside legacy mode");

  property p_status_len;
    @(posedge ref_clk) disable iff (if_off)
      $rose(state_ff == S_STATUS) && !rx_active |-> (ctl_o == lli_pkg::CTL_STATUS)[*8];
  endproperty
  a_status_len: assert property (p_status_len)
    else $error("status transfer shorter than eight beats");
endmodule

// ### verif/lli_llc_model.sv
`timescale 1ns/1ps
module lli_llc_model #(
  parameter int TX_BEATS = 3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] ctl_o,
  input wire logic ctl_oe,
  input wire logic [7:0] data_o,
  input wire logic data_oe,
  input wire logic [3:0] hold_cyc,
  input wire logic [7:0] tx_byte,
  output logic link_request_line,
  output logic [1:0] ctl_i,
  output logic [7:0] data_i
);
  logic own_ff;
  int cnt_ff;
  logic [1:0] llc_ctl;

  initial link_request_line = 1'b0;

  // line idles low, one bit per edge, bit n-1 of the vector sent first and bit 0 last
  task automatic send_req(input logic [16:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge ref_clk);
      link_request_line <= bits[i];
    end
    @(posedge ref_clk);
    link_request_line <= 1'b0;
  endtask

  // takes the buses only after a grant, gives them back with 00
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      own_ff <= 1'b0;
      cnt_ff <= 0;
    end else if (!own_ff && ctl_oe && ctl_o == lli_pkg::CTL_GRANT) begin
      own_ff <= 1'b1;
      cnt_ff <= 0;
    end else if (own_ff) begin
      own_ff <= (cnt_ff < hold_cyc + TX_BEATS);
      cnt_ff <= cnt_ff + 1;
    end
  end

  // hold first (slow answer when hold_cyc > 0), then transmit, never 11
  assign llc_ctl = (cnt_ff < hold_cyc) ? lli_pkg::CTL_HOLD :
                   (cnt_ff < hold_cyc + TX_BEATS) ? lli_pkg::CTL_TRANSMIT :
                   lli_pkg::CTL_IDLE;
  // nobody driving: show the inverse of the last value, not a clean zero
  assign ctl_i = ctl_oe ? ctl_o : own_ff ? llc_ctl : ~ctl_o;
  // upper lanes carry junk so the device must mask them
  assign data_i = data_oe ? data_o : own_ff ? tx_byte : ~data_o;
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic rst_n, bus_mode_select, link_power_status, link_active_bit, wake_pulse, irq_pending;
  logic link_request_line, ctl_oe, data_oe, link_on_wake_output, iface_clk_run, bus_reset;
  logic bus_idle_detected, subaction_gap_detected, arb_won, arb_lost, rx_active, stat_auto_req;
  logic take_bus_now, arbitrate_now, fair_protocol, reg_wr_valid, reg_rd_pending, accel_enable;
  logic stat_done, tx_done;
  logic [1:0] ctl_i, ctl_o;
  logic [7:0] data_i, data_o, rx_data, reg_rd_data, reg_wr_data, wr_d;
  logic [2:0] rx_speed, spd;
  logic [3:0] reg_addr, hold_cyc, wr_a;
  logic [15:0] stat_auto_word, st_word;
  logic [5:0] st_hi;
  logic [7:0] gr_cnt, tx_cnt, st_cnt, done_cnt, wr_cnt, sd_cnt;
  lli_pkg::lli_busreq_t pend_req;
  lli_pkg::lli_tx_t tx_out, tx_last;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;

  always #10 ref_clk = ~ref_clk;

  lli_phy_link_if u_dut (.ref_clk, .rst_n, .bus_mode_select, .link_power_status,
    .link_active_bit, .wake_pulse, .irq_pending, .link_request_line, .ctl_i, .ctl_o, .ctl_oe,
    .data_i, .data_o, .data_oe, .link_on_wake_output, .iface_clk_run, .bus_reset,
    .bus_idle_detected, .subaction_gap_detected, .arb_won, .arb_lost, .rx_active, .rx_data,
    .rx_speed, .stat_auto_req, .stat_auto_word, .reg_rd_data, .pend_req, .take_bus_now,
    .arbitrate_now, .fair_protocol, .reg_wr_valid, .reg_addr, .reg_wr_data, .reg_rd_pending,
    .accel_enable, .stat_done, .tx_out, .tx_done);

  lli_llc_model u_llc (.ref_clk, .rst_n, .ctl_o, .ctl_oe, .data_o, .data_oe, .hold_cyc,
    .tx_byte(8'hFF), .link_request_line, .ctl_i, .data_i);

  // registered outputs are read before this edge's updates land
  always @(posedge ref_clk) begin
    if (reg_wr_valid === 1'b1) begin
      wr_cnt = wr_cnt + 8'h01;
      wr_a = reg_addr;
      wr_d = reg_wr_data;
    end
    if (tx_out.valid === 1'b1) begin
      tx_cnt = tx_cnt + 8'h01;
      tx_last = tx_out;
    end
    if (ctl_oe === 1'b1 && ctl_o === lli_pkg::CTL_STATUS) begin
      st_cnt = st_cnt + 8'h01;
      st_word = {st_word[13:0], data_o[1:0]};
      st_hi = st_hi | data_o[7:2];
    end
    if (ctl_oe === 1'b1 && ctl_o === lli_pkg::CTL_GRANT) gr_cnt = gr_cnt + 8'h01;
    if (tx_done === 1'b1) done_cnt = done_cnt + 8'h01;
    if (stat_done === 1'b1) sd_cnt = sd_cnt + 8'h01;
  end

  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // cleared between edges so the capture block never races it
  task automatic clr();
    @(negedge ref_clk);
    gr_cnt = 8'h00;
    tx_cnt = 8'h00;
    st_cnt = 8'h00;
    done_cnt = 8'h00;
    wr_cnt = 8'h00;
    sd_cnt = 8'h00;
    st_hi = 6'h00;
    tick(1);
  endtask

  // well above the few hundred cycles the sequence needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    {rst_n, bus_mode_select, wake_pulse, irq_pending, bus_reset, arb_won, arb_lost} = 7'h00;
    {bus_idle_detected, subaction_gap_detected, rx_active, stat_auto_req} = 4'h0;
    {link_power_status, link_active_bit} = 2'h3;
    {rx_data, rx_speed, reg_rd_data, hold_cyc, stat_auto_word} = 39'h0;
    tick(4);
    rst_n <= 1'b1;
    clr();
    tick(3);
    @(negedge ref_clk);
    chk("idle bus", {1'b1, lli_pkg::CTL_IDLE}, {ctl_oe, ctl_o});
    chk("clock run", 17'h1, iface_clk_run);
    u_llc.send_req({1'b1, lli_pkg::RQ_WR, 4'h5, 8'hA5, 1'b0}, 17);
    tick(4);
    @(negedge ref_clk);
    chk("write", {8'h01, 4'h5, 8'hA5}, {wr_cnt, wr_a, wr_d});
    u_llc.send_req({11'h0, 1'b1, lli_pkg::RQ_ACCEL, 2'h0}, 6);
    u_llc.send_req({11'h0, 1'b1, lli_pkg::RQ_RSV, 2'h0}, 6);
    tick(4);
    @(negedge ref_clk);
    chk("accel off", {8'h01, 2'h0}, {wr_cnt, pend_req.valid, accel_enable});
    u_llc.send_req({11'h0, 1'b1, lli_pkg::RQ_ACCEL, 2'h2}, 6);
    tick(4);
    @(negedge ref_clk);
    chk("accel on", 17'h1, accel_enable);
    for (int t = 0; t < 4; t++) begin
      u_llc.send_req({10'h0, 1'b1, t[2:0], lli_pkg::SPD_S200}, 7);
      tick(4);
      bus_idle_detected <= 1'b1;
      @(negedge ref_clk);
      chk("pending", {1'b1, t[2:0], lli_pkg::SPD_S200}, pend_req);
      chk("take bus", t == 0, take_bus_now);
      chk("arb on idle", t == 1, arbitrate_now);
      tick(1);
      bus_idle_detected <= 1'b0;
      subaction_gap_detected <= 1'b1;
      @(negedge ref_clk);
      chk("arb on gap", {t > 1, t == 3}, {arbitrate_now, fair_protocol});
      u_llc.send_req({9'h0, 1'b1, lli_pkg::RQ_ISO, lli_pkg::SPD_S400, 1'b0}, 8);
      tick(4);
      @(negedge ref_clk);
      chk("second ignored", {1'b1, t[2:0]}, pend_req[6:3]);
      tick(1);
      arb_lost <= (t == 1);
      tick(1);
      arb_lost <= 1'b0;
      @(negedge ref_clk);
      chk("iso kept on loss", 17'h1, pend_req.valid);
      tick(1);
      subaction_gap_detected <= 1'b0;
      bus_reset <= 1'b1;
      tick(1);
      bus_reset <= 1'b0;
      tick(2);
      @(negedge ref_clk);
      chk("bus reset clears", 17'h0, pend_req.valid);
    end
    for (int s = 0; s < 3; s++) begin
      spd = (s == 0) ? lli_pkg::SPD_S100 : (s == 1) ? lli_pkg::SPD_S400 : 3'h3;
      u_llc.send_req({9'h0, 1'b1, lli_pkg::RQ_FAIR, spd, 1'b0}, 8);
      tick(3);
      clr();
      hold_cyc <= s[3:0];
      arb_won <= 1'b1;
      tick(1);
      arb_won <= 1'b0;
      tick(14);
      @(negedge ref_clk);
      chk("grant once", {8'h01, 8'h01}, {gr_cnt, done_cnt});
      chk("tx beats", 17'h3, tx_cnt);
      chk("tx data", (s == 0) ? 10'h203 : (s == 1) ? 10'h2FF : 10'h300, tx_last);
      chk("bus back", {1'b1, lli_pkg::CTL_IDLE}, {ctl_oe, ctl_o});
    end
    clr();
    reg_rd_data <= 8'h3C;
    u_llc.send_req({8'h0, 1'b1, lli_pkg::RQ_RD, 4'h9, 1'b0}, 9);
    tick(20);
    @(negedge ref_clk);
    chk("status word", {4'h9, 8'h3C, 4'h0}, st_word);
    chk("status beats", {8'h08, 6'h00, 1'b0}, {st_cnt, st_hi, reg_rd_pending});
    clr();
    stat_auto_word <= 16'hC35A;
    stat_auto_req <= 1'b1;
    tick(1);
    stat_auto_req <= 1'b0;
    tick(12);
    @(negedge ref_clk);
    chk("auto status word", 16'hC35A, st_word);
    chk("auto status beats", {8'h08, 8'h01}, {st_cnt, sd_cnt});
    tick(1);
    rx_speed <= lli_pkg::SPD_S200;
    rx_data <= 8'hFF;
    rx_active <= 1'b1;
    tick(3);
    @(negedge ref_clk);
    chk("receive", {lli_pkg::CTL_RECEIVE, 8'h0F}, {ctl_o, data_o});
    tick(1);
    rx_active <= 1'b0;
    irq_pending <= 1'b1;
    link_active_bit <= 1'b0;
    tick(3);
    @(negedge ref_clk);
    chk("irq link bit", 17'h1, link_on_wake_output);
    tick(1);
    link_active_bit <= 1'b1;
    tick(3);
    @(negedge ref_clk);
    chk("irq masked", 17'h0, link_on_wake_output);
    tick(1);
    wake_pulse <= 1'b1;
    tick(1);
    wake_pulse <= 1'b0;
    @(negedge ref_clk);
    chk("wake", 17'h1, link_on_wake_output);
    tick(1);
    link_power_status <= 1'b0;
    tick(3);
    @(negedge ref_clk);
    chk("power off", 17'h4, {link_on_wake_output, ctl_oe, iface_clk_run});
    tick(1);
    link_power_status <= 1'b1;
    irq_pending <= 1'b0;
    bus_mode_select <= 1'b1;
    tick(4);
    @(negedge ref_clk);
    chk("mode high", 17'h0, {ctl_oe, data_oe, iface_clk_run});
    tick(1);
    bus_mode_select <= 1'b0;
    tick(4);
    @(negedge ref_clk);
    chk("mode low", {1'b1, lli_pkg::CTL_IDLE, 1'b1}, {ctl_oe, ctl_o, iface_clk_run});
    test_done();
  end
endmodule
